// *** src/gfm_mux.sv ***
`default_nettype none
module gfm_mux #(
    parameter int unsigned LANE_W = 3
) (
    input  wire logic                                clk,
    input  wire logic                                arst_n,
    input  wire logic [gfm_pkg::NUM_PINS-1:0]        pad_i,
    output logic      [gfm_pkg::NUM_PINS-1:0]        pad_o,
    output logic      [gfm_pkg::NUM_PINS-1:0]        pad_oe_n,
    input  wire logic [2*gfm_pkg::NUM_PINS-1:0]      pin_mode,
    input  wire logic [gfm_pkg::NUM_PINS-1:0]        gpio_out,
    input  wire logic [gfm_pkg::NUM_PINS-1:0]        alt_sel,
    input  wire gfm_pkg::gfm_aux_t                   aux_func,
    input  wire gfm_pkg::gfm_spi_out_t               spi_out,
    input  wire logic                                stereo_left,
    output logic      [gfm_pkg::NUM_PINS-1:0]        gpio_in,
    output logic                                     pmic_port_miso,
    output logic      [LANE_W-1:0]                   lane_count,
    output logic                                     boot_done
);
    // lane count from strap code
    function automatic logic [LANE_W-1:0] code_to_lanes(input logic [1:0] c);
        code_to_lanes = LANE_W'(c) + LANE_W'(gfm_pkg::LANE_COUNT_ONE);
    endfunction

    typedef struct packed {
        logic [gfm_pkg::NUM_PINS-1:0] gin;
        logic                         miso;
        logic [LANE_W-1:0]            lanes;
        logic                         done;
    } gfm_top_st_t;

    gfm_top_st_t st_r;
    gfm_top_st_t st_nxt;

    logic [1:0]                   code;
    logic                         strap_done;
    logic [gfm_pkg::NUM_PINS-1:0] alt_en;
    logic [gfm_pkg::NUM_PINS-1:0] alt_val;
    logic [2*gfm_pkg::NUM_PINS-1:0] cell_mode;

    gfm_strap u_strap (
        .clk       (clk),
        .arst_n    (arst_n),
        .strap_hi  (pad_i[gfm_pkg::PIN_MOSI]),
        .strap_lo  (pad_i[gfm_pkg::PIN_SCLK]),
        .lane_code (code),
        .boot_done (strap_done)
    );

    // alternate functions; straps stay released until the capture is done
    always_comb begin
        alt_en  = '0;
        alt_val = '0;
        cell_mode = pin_mode;
        // a plain output on a strap pin would overdrive the board resistor
        if (!strap_done) begin
            cell_mode[2*gfm_pkg::PIN_SCLK +: 2] = gfm_pkg::GFM_MODE_IN;
            cell_mode[2*gfm_pkg::PIN_MOSI +: 2] = gfm_pkg::GFM_MODE_IN;
        end
        alt_en[gfm_pkg::PIN_SCLK]  = alt_sel[gfm_pkg::PIN_SCLK] & strap_done;
        alt_val[gfm_pkg::PIN_SCLK] = spi_out.sclk;
        alt_en[gfm_pkg::PIN_MOSI]  = alt_sel[gfm_pkg::PIN_MOSI] & strap_done;
        alt_val[gfm_pkg::PIN_MOSI] = spi_out.mosi;
        alt_en[gfm_pkg::PIN_SEL_A]  = alt_sel[gfm_pkg::PIN_SEL_A];
        alt_val[gfm_pkg::PIN_SEL_A] = spi_out.sel_a_n;
        if (aux_func == gfm_pkg::GFM_AUX_STEREO) begin
            alt_en[gfm_pkg::PIN_AUX]  = 1'b1;
            alt_val[gfm_pkg::PIN_AUX] = stereo_left;
        end else if (aux_func == gfm_pkg::GFM_AUX_SEL_B) begin
            alt_en[gfm_pkg::PIN_AUX]  = 1'b1;
            alt_val[gfm_pkg::PIN_AUX] = spi_out.sel_b_n;
        end
    end

    // one driver cell per pin
    for (genvar i = 0; i < gfm_pkg::NUM_PINS; i++) begin : g_cell
        gfm_pin_cell u_cell (
            .clk      (clk),
            .arst_n   (arst_n),
            .mode     (gfm_pkg::gfm_mode_t'(cell_mode[2*i +: 2])),
            .gpio_out (gpio_out[i]),
            .alt_en   (alt_en[i]),
            .alt_out  (alt_val[i]),
            .pad_o    (pad_o[i]),
            .pad_oe_n (pad_oe_n[i])
        );
    end

    // registered inputs and status
    always_comb begin
        st_nxt       = st_r;
        st_nxt.gin   = pad_i;
        st_nxt.miso  = pad_i[gfm_pkg::PIN_MISO];
        st_nxt.lanes = code_to_lanes(code);
        st_nxt.done  = strap_done;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{gin: '0, miso: 1'b0,
                      lanes: LANE_W'(gfm_pkg::LANE_COUNT_ONE), done: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign gpio_in        = st_r.gin;
    assign pmic_port_miso = st_r.miso;
    assign lane_count     = st_r.lanes;
    assign boot_done      = st_r.done;
endmodule
`default_nettype wire

// *** src/gfm_pin_cell.sv ***
`default_nettype none
// one pad driver: plain mode or alternate output
module gfm_pin_cell (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire gfm_pkg::gfm_mode_t mode,
    input  wire logic              gpio_out,
    input  wire logic              alt_en,
    input  wire logic              alt_out,
    output logic                   pad_o,
    output logic                   pad_oe_n
);
    typedef struct packed {
        logic o;
        logic oe_n;
    } gfm_cell_st_t;

    gfm_cell_st_t st_r;
    gfm_cell_st_t st_nxt;

    // pad drive: oe_n low means the pad is driven
    always_comb begin
        st_nxt = '{o: 1'b0, oe_n: 1'b1};
        if (alt_en) begin
            st_nxt.o    = alt_out;
            st_nxt.oe_n = 1'b0;
        end else begin
            case (mode)
                gfm_pkg::GFM_MODE_IN: begin
                    st_nxt.oe_n = 1'b1;
                end
                gfm_pkg::GFM_MODE_OUT, gfm_pkg::GFM_MODE_BIDIR: begin
                    st_nxt.o    = gpio_out;
                    st_nxt.oe_n = 1'b0;
                end
                gfm_pkg::GFM_MODE_OD: begin
                    // only pull low; board pull-up gives the high
                    st_nxt.o    = 1'b0;
                    st_nxt.oe_n = gpio_out;
                end
                default: begin
                    st_nxt.oe_n = 1'b1;
                end
            endcase
        end
    end

    // released pad during reset so board pulls hold the lines
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{o: 1'b0, oe_n: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pad_o    = st_r.o;
    assign pad_oe_n = st_r.oe_n;
endmodule
`default_nettype wire

// *** src/gfm_pkg.sv ***
`default_nettype none
package gfm_pkg;
    // pin count handled by this block
    localparam int unsigned NUM_PINS = 5;

    // pin indices
    localparam int unsigned PIN_MISO  = 0;
    localparam int unsigned PIN_SCLK  = 1;
    localparam int unsigned PIN_MOSI  = 2;
    localparam int unsigned PIN_SEL_A = 3;
    localparam int unsigned PIN_AUX   = 4;

    // plain pin modes chosen by software
    typedef enum logic [1:0] {
        GFM_MODE_IN    = 2'h0,
        GFM_MODE_OUT   = 2'h1,
        GFM_MODE_BIDIR = 2'h2,
        GFM_MODE_OD    = 2'h3
    } gfm_mode_t;

    // pin 4 alternate function choice
    typedef enum logic [1:0] {
        GFM_AUX_GPIO   = 2'h0,
        GFM_AUX_STEREO = 2'h1,
        GFM_AUX_SEL_B  = 2'h2
    } gfm_aux_t;

    // lane count codes, count = code + 1
    localparam logic [1:0] LANE_CODE_RESET = 2'h0;
    localparam logic [2:0] LANE_COUNT_ONE  = 3'h1;

    // boot phase states
    typedef enum logic [2:0] {
        GFM_ST_RESET  = 3'h1,
        GFM_ST_SAMPLE = 3'h2,
        GFM_ST_RUN    = 3'h4
    } gfm_state_t;

    // serial master signals toward the pins
    typedef struct packed {
        logic sclk;
        logic mosi;
        logic sel_a_n;
        logic sel_b_n;
    } gfm_spi_out_t;

    // two-signal bundle covering all NUM_PINS pins
    typedef struct packed {
        logic [NUM_PINS-1:0] o;
        logic [NUM_PINS-1:0] oe_n;
    } gfm_pin_drv_t;
endpackage
`default_nettype wire

// *** src/gfm_strap.sv ***
`default_nettype none
// lane strap capture at the second edge after reset release
module gfm_strap (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       strap_hi,
    input  wire logic       strap_lo,
    output logic [1:0]      lane_code,
    output logic            boot_done
);
    typedef struct packed {
        gfm_pkg::gfm_state_t state;
        logic [1:0]          code;
    } gfm_strap_st_t;

    gfm_strap_st_t st_r;
    gfm_strap_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        case (st_r.state)
            gfm_pkg::GFM_ST_RESET: begin
                st_nxt.state = gfm_pkg::GFM_ST_SAMPLE;
            end
            gfm_pkg::GFM_ST_SAMPLE: begin
                st_nxt.code  = {strap_hi, strap_lo};
                st_nxt.state = gfm_pkg::GFM_ST_RUN;
            end
            gfm_pkg::GFM_ST_RUN: begin
                st_nxt.state = gfm_pkg::GFM_ST_RUN;
            end
            default: begin
                st_nxt.state = gfm_pkg::GFM_ST_RUN;
            end
        endcase
    end

    // constant at reset; the strap level is taken by a clocked edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{state: gfm_pkg::GFM_ST_RESET, code: gfm_pkg::LANE_CODE_RESET};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lane_code = st_r.code;
    assign boot_done = (st_r.state == gfm_pkg::GFM_ST_RUN);
endmodule
`default_nettype wire

// *** verification/gfm_mux_assertions.sv ***
`default_nettype none
module gfm_mux_assertions #(
    parameter int unsigned LANE_W = 3
) (
    input wire logic                  clk,
    input wire logic                  arst_n,
    input wire logic [4:0]            pad_i,
    input wire logic [4:0]            pad_o,
    input wire logic [4:0]            pad_oe_n,
    input wire logic [9:0]            pin_mode,
    input wire logic [4:0]            gpio_out,
    input wire logic [4:0]            alt_sel,
    input wire gfm_pkg::gfm_aux_t     aux_func,
    input wire gfm_pkg::gfm_spi_out_t spi_out,
    input wire logic                  stereo_left,
    input wire logic [4:0]            gpio_in,
    input wire logic                  pmic_port_miso,
    input wire logic [LANE_W-1:0]     lane_count,
    input wire logic                  boot_done
);
    timeunit 1ns;
    timeprecision 1ns;
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sel_a_map_a: assert property (
        alt_sel[3] |=> !pad_oe_n[3] && pad_o[3] == $past(spi_out.sel_a_n)) else $error("sel a");
    sclk_map_a: assert property (
        boot_done && alt_sel[1] |=> !pad_oe_n[1] && pad_o[1] == $past(spi_out.sclk)) else $error("sclk");
    mosi_map_a: assert property (
        boot_done && alt_sel[2] |=> !pad_oe_n[2] && pad_o[2] == $past(spi_out.mosi)) else $error("mosi");
    stereo_map_a: assert property (
        aux_func == gfm_pkg::GFM_AUX_STEREO |=> !pad_oe_n[4] && pad_o[4] == $past(stereo_left))
        else $error("stereo");
    sel_b_map_a: assert property (
        aux_func == gfm_pkg::GFM_AUX_SEL_B |=> !pad_oe_n[4] && pad_o[4] == $past(spi_out.sel_b_n))
        else $error("sel b");
    pad_follow_a: assert property (
        1'b1 |=> gpio_in == $past(pad_i) && pmic_port_miso == $past(pad_i[0])) else $error("input");
    od_pin_a: assert property (
        pin_mode[1:0] == 2'h3 |=> pad_oe_n[0] == $past(gpio_out[0]) && (pad_oe_n[0] || !pad_o[0]))
        else $error("open drain");
    lane_cap_a: assert property (
        $rose(boot_done) |-> lane_count == LANE_W'($past(pad_i[2:1], 2)) + LANE_W'(1))
        else $error("lane");
    strap_float_a: assert property (
        !boot_done |-> &pad_oe_n[2:1]) else $error("strap pins driven");
    lane_hold_a: assert property (
        boot_done |=> boot_done && $stable(lane_count)) else $error("lane hold");
    cover property ($rose(boot_done));
    cover property (aux_func == gfm_pkg::GFM_AUX_SEL_B);
    cover property (alt_sel[3] && !spi_out.sel_a_n);
endmodule
bind gfm_mux gfm_mux_assertions #(.LANE_W(LANE_W)) chk_inst (.clk(clk), .arst_n(arst_n),
    .pad_i(pad_i), .pad_o(pad_o), .pad_oe_n(pad_oe_n), .pin_mode(pin_mode), .gpio_out(gpio_out),
    .alt_sel(alt_sel), .aux_func(aux_func), .spi_out(spi_out), .stereo_left(stereo_left),
    .gpio_in(gpio_in), .pmic_port_miso(pmic_port_miso), .lane_count(lane_count),
    .boot_done(boot_done));
`default_nettype wire

// *** verification/gfm_pmic_model.sv ***
`default_nettype none
module gfm_pmic_model (
    input  wire logic [4:0] pad_o,
    input  wire logic [4:0] pad_oe_n,
    input  wire logic [1:0] strap_code,
    input  wire logic       miso_val,
    output logic      [4:0] pad_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       miso_w;
    logic [4:0] pull;
    // board pulls: strap resistors, selects and aux held high
    assign pull = {2'b11, strap_code, 1'b0};
    // answer only while selected; a released line shows the inverse
    assign miso_w = (!pad_oe_n[3] && !pad_o[3]) ? miso_val : !miso_val;
    // wire level: driver wins, else pull or model
    assign pad_i = (pad_o & ~pad_oe_n) | ({pull[4:1], miso_w} & pad_oe_n);
endmodule
`default_nettype wire

// *** verification/tb.sv ***
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [4:0] alt; logic [1:0] aux; logic [9:0] mode; logic [4:0] gout;
        logic [3:0] spi; logic st; logic [4:0] o; logic [4:0] oe;
    } gfm_row_t;
    logic                  clk, arst_n, stereo_left, pmic_port_miso, boot_done, miso_val;
    logic [4:0]            pad_i, pad_o, pad_oe_n, gpio_out, alt_sel, gpio_in;
    logic [9:0]            pin_mode;
    logic [2:0]            lane_count;
    logic [1:0]            strap_code;
    gfm_pkg::gfm_aux_t     aux_func;
    gfm_pkg::gfm_spi_out_t spi_out;
    int                    fail_count, n_checks;
    // o column holds pad_o with undriven pins forced high
    gfm_row_t rows [8] = '{
        '{5'h00, 2'h0, 10'h155, 5'h15, 4'h0, 1'h0, 5'h15, 5'h00},
        '{5'h00, 2'h0, 10'h000, 5'h1F, 4'h0, 1'h0, 5'h1F, 5'h1F},
        '{5'h00, 2'h0, 10'h3FF, 5'h0A, 4'h0, 1'h0, 5'h0A, 5'h0A},
        '{5'h0E, 2'h1, 10'h000, 5'h00, 4'h9, 1'h1, 5'h13, 5'h01},
        '{5'h0E, 2'h2, 10'h000, 5'h00, 4'h6, 1'h1, 5'h0D, 5'h01},
        '{5'h0E, 2'h1, 10'h000, 5'h00, 4'hF, 1'h0, 5'h0F, 5'h01},
        '{5'h11, 2'h0, 10'h155, 5'h00, 4'h0, 1'h0, 5'h00, 5'h00},
        '{5'h00, 2'h3, 10'h155, 5'h10, 4'h0, 1'h0, 5'h10, 5'h00}};
    gfm_mux #(.LANE_W(3)) gfm_mux_inst (.clk(clk), .arst_n(arst_n), .pad_i(pad_i),
        .pad_o(pad_o), .pad_oe_n(pad_oe_n), .pin_mode(pin_mode), .gpio_out(gpio_out),
        .alt_sel(alt_sel), .aux_func(aux_func), .spi_out(spi_out), .stereo_left(stereo_left),
        .gpio_in(gpio_in), .pmic_port_miso(pmic_port_miso), .lane_count(lane_count),
        .boot_done(boot_done));
    gfm_pmic_model gfm_pmic_model_inst (.pad_o(pad_o), .pad_oe_n(pad_oe_n),
        .strap_code(strap_code), .miso_val(miso_val), .pad_i(pad_i));
    // free-running core clock, 100 ns
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(string nm, logic [4:0] exp, logic [4:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // reset with a strap code, then check the latched lane count
    task automatic boot(logic [1:0] code);
        @(negedge clk);
        arst_n = 1'b0;
        strap_code = code;
        repeat (16) @(negedge clk);
        chk("oe_n in reset", 5'h1F, pad_oe_n);
        chk("boot in reset", 5'h00, {4'h0, boot_done});
        arst_n = 1'b1;
        @(negedge clk);
        chk("strap pins released", 5'h06, pad_oe_n & 5'h06);
        for (int i = 0; i < 10 && boot_done !== 1'b1; i++) @(negedge clk);
        chk("boot_done", 5'h01, {4'h0, boot_done});
        if (boot_done !== 1'b1) tally_and_finish();
        chk("lanes", {2'h0, code} + 5'h01, {2'h0, lane_count});
        strap_code = ~code;
        repeat (3) @(negedge clk);
        chk("lanes held", {2'h0, code} + 5'h01, {2'h0, lane_count});
    endtask
    initial begin
        {arst_n, stereo_left, miso_val, gpio_out, alt_sel, pin_mode, strap_code} = '0;
        aux_func = gfm_pkg::GFM_AUX_GPIO;
        spi_out = '0;
        fail_count = 0;
        n_checks = 0;
        boot(2'h0);
        // each row applied, then pads checked two clock cycles later
        foreach (rows[k]) begin
            alt_sel = rows[k].alt;
            aux_func = gfm_pkg::gfm_aux_t'(rows[k].aux);
            pin_mode = rows[k].mode;
            gpio_out = rows[k].gout;
            spi_out = gfm_pkg::gfm_spi_out_t'(rows[k].spi);
            stereo_left = rows[k].st;
            miso_val = k[0];
            repeat (2) @(negedge clk);
            chk("pad_oe_n", rows[k].oe, pad_oe_n);
            chk("pad_o", rows[k].o, pad_o | pad_oe_n);
            chk("gpio_in", pad_i, gpio_in);
            chk("miso", {4'h0, pad_i[0]}, {4'h0, pmic_port_miso});
        end
        // straps must still be read with pins 1 and 2 set to drive
        alt_sel = 5'h06;
        for (int c = 0; c < 4; c++) boot(2'(c));
        tally_and_finish();
    end
endmodule
`default_nettype wire
